// ### rtl/setup_pkg.sv
// Purpose: Shared constants and types for the setup block loader and alert output.
// Assumes: 200 MHz system clock; byte offsets index the 247-byte setup image.
// Notes:   Timing counts are derived here from the printed times.
package setup_pkg;

  // ---------------------------------------------------------------------------
  // Image layout
  // ---------------------------------------------------------------------------
  localparam int         NUM_KEYS          = 48;
  localparam int         BLOCK_LEN         = 247;
  localparam int         OFS_THRESH        = 0;    // key_threshold_pairs
  localparam int         OFS_DRIFT         = 48;
  localparam int         OFS_INTEG         = 96;
  localparam int         OFS_NEG_RECAL     = 144;  // key_neg_recal_delay
  localparam int         OFS_OPTIONS       = 192;  // key_burst_options
  localparam int         OFS_GLOBAL        = 240;
  localparam int         OFS_SPACING_BAUD  = 241;  // spacing_and_baud
  localparam int         OFS_FLOOR         = 242;  // signal_floor, low byte first
  localparam int         OFS_ALERT_CTRL    = 244;  // alert_pin_control
  localparam int         OFS_CHECKSUM      = 245;  // setup_block_checksum, low first
  localparam logic [7:0] SETUP_CMD         = 8'h01;
  localparam logic [4:0] THRESH_BIAS       = 5'h04;

  // ---------------------------------------------------------------------------
  // Reset image bytes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_THRESH        = 8'h26;
  localparam logic [7:0] RST_DRIFT         = 8'h0A;
  localparam logic [7:0] RST_INTEG         = 8'h52;
  localparam logic [7:0] RST_NEG_RECAL     = 8'h14;
  localparam logic [7:0] RST_OPTIONS       = 8'h26;
  localparam logic [7:0] RST_GLOBAL        = 8'h11;
  localparam logic [7:0] RST_SPACING_BAUD  = 8'h00;
  localparam logic [7:0] RST_FLOOR_LO      = 8'h64;
  localparam logic [7:0] RST_FLOOR_HI      = 8'h00;
  localparam logic [7:0] RST_ALERT_CTRL    = 8'h6C;
  localparam logic [15:0] CRC_POLY         = 16'h1021;
  localparam logic [15:0] CRC_INIT         = 16'h0000;

  // ---------------------------------------------------------------------------
  // Alert control bit positions
  // ---------------------------------------------------------------------------
  localparam int ALB_POLARITY  = 7;
  localparam int ALB_KEY_ERR   = 6;
  localparam int ALB_TOUCH     = 5;
  localparam int ALB_SLEEP     = 4;
  localparam int ALB_NVM_ERR   = 3;
  localparam int ALB_MAINS_ERR = 2;
  localparam int ALB_COMMS_ERR = 1;
  localparam int ALB_WATCHDOG  = 0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam longint CLK_PERIOD_PS     = 5000;
  localparam longint PS_PER_MS         = 64'd1_000_000_000;
  localparam longint WD_TIMEOUT_MS     = 2000;
  localparam longint WD_PULSE_MS       = 150;
  localparam longint MAINS_TIMEOUT_MS  = 100;
  localparam int unsigned WD_TIMEOUT_CYCLES = 32'(WD_TIMEOUT_MS * PS_PER_MS / CLK_PERIOD_PS);
  localparam int unsigned WD_PULSE_CYCLES   = 32'(WD_PULSE_MS * PS_PER_MS / CLK_PERIOD_PS);
  localparam int unsigned MAINS_CYCLES      = 32'(MAINS_TIMEOUT_MS * PS_PER_MS / CLK_PERIOD_PS);

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    LD_IDLE  = 2'b00,
    LD_SETUP = 2'b01,
    LD_LOAD  = 2'b10
  } load_state_type;

  typedef struct packed {
    logic [4:0] neg_threshold;
    logic [4:0] pos_threshold;
    logic [3:0] neg_drift_rate;
    logic [3:0] pos_drift_rate;
    logic [3:0] normal_integrator_limit;
    logic [3:0] fast_integrator_limit;
    logic [7:0] neg_recal_delay;
    logic [3:0] pos_recal_delay;
    logic [1:0] burst_length;
    logic       adjacent_suppress;
    logic       scope_trigger_enable;
  } key_setup_type;

  typedef struct packed {
    logic [3:0]  release_margin;
    logic [1:0]  dwell_code;
    logic        mains_lock_enable;
    logic [3:0]  burst_spacing;
    logic [3:0]  baud_select;
    logic [15:0] signal_floor;
    logic [7:0]  alert_pin_control;
  } global_setup_type;

endpackage : setup_pkg

// ### rtl/setup_block_alert_output.sv
// Purpose: Setup image loader for a touch-key matrix controller and its alert output pin.
// Assumes: Host bytes arrive already deframed as one-cycle strobes; sensing core drives
//          the status inputs; all inputs are synchronous to clk_sys_i.
// Notes:   Image is staged and committed only when its checksum matches.
// Notes on behaviour
// - Alert is active when any enabled condition holds, all OR-ed together.
// - Control bit 7 set means active-high alert, clear means active-low.
// - Control bit 6 lets any key error, including low signal, raise alert.
// - Control bit 5 makes alert active while any key is touched.
// - Control bit 4 makes alert active while the device sleeps.
// - Control bit 3 makes a nonvolatile memory error raise alert.
// - Control bit 2 makes a mains synchronisation error raise alert.
// - Control bit 1: unknown command latches alert until get-last-command or reset.
// - Control bit 0: two seconds without host traffic gives 150 ms alert pulse.
// - Watchdog stays disarmed after reset until a first valid command arrives.
// - Alert level is frozen while the device stays in sleep.
// - Alert control byte resets to 0x6C.
// - 247-byte block accepted only in setup mode, entered by two 0x01 commands.
// - Threshold byte: low nibble negative, high nibble positive, each plus four.
// - Drift byte: low nibble negative, high nibble positive drift code.
// - Integrator byte: low nibble normal limit, high nibble fast limit.
// - Negative recalibration delay in half seconds, zero infinite, default 20.
// - Option byte: bits 5:4 burst length, bit 6 suppression, bit 7 scope.
// - Global byte: low nibble margin, bits 5:4 dwell, bit 6 mains lock.
// - Byte 241: low nibble burst spacing, high nibble baud select.
// - Two-byte signal floor, low first; key signal below it is an error.
// - Mains lock with no sync edge within 100 ms raises mains error.
`timescale 1ns/1ps
`default_nettype none

module setup_block_alert_output
  import setup_pkg::*;
#(
  parameter int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_CYCLES,
  parameter int unsigned WD_PULSE_CYC   = WD_PULSE_CYCLES,
  parameter int unsigned MAINS_CYC      = MAINS_CYCLES
) (
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  input  wire logic             rx_valid_i,
  input  wire logic [7:0]       rx_byte_i,
  input  wire logic             valid_cmd_i,
  input  wire logic             unknown_cmd_i,
  input  wire logic             get_last_cmd_i,
  input  wire logic             key_error_i,
  input  wire logic             key_touch_i,
  input  wire logic             sleep_i,
  input  wire logic             nvm_error_i,
  input  wire logic             scan_done_i,
  input  wire logic             mains_edge_i,
  input  wire logic [10:0]      key_signal_i,
  input  wire logic [5:0]       key_sel_i,
  output logic                  alert_pin_o,
  output logic                  setup_mode_o,
  output logic                  load_ok_o,
  output logic                  load_bad_o,
  output logic                  low_signal_o,
  output logic                  mains_error_o,
  output var key_setup_type     key_setup_o,
  output var global_setup_type  global_setup_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef logic [BLOCK_LEN-1:0][7:0] image_type;

  typedef struct packed {
    load_state_type   ld;
    logic             saw_setup;
    logic [7:0]       cnt;
    logic [15:0]      crc;
    logic [7:0]       crc_lo;
    image_type        shadow;
    image_type        active;
    logic             load_ok;
    logic             load_bad;
    logic             comms_flag;
    logic             wd_armed;
    logic [31:0]      wd_cnt;
    logic             wd_pulse;
    logic [31:0]      pulse_cnt;
    logic             mains_wait;
    logic [31:0]      mains_cnt;
    logic             mains_err;
    logic             low_sig;
    logic             sleep_q;
    logic             alert;
    key_setup_type    key_out;
    global_setup_type glb_out;
  } state_type;

  // Builds the power-on image from the documented defaults.
  function automatic image_type default_image();
    image_type img;
    img = '0;
    for (int k = 0; k < NUM_KEYS; k++) begin
      img[OFS_THRESH + k]    = RST_THRESH;
      img[OFS_DRIFT + k]     = RST_DRIFT;
      img[OFS_INTEG + k]     = RST_INTEG;
      img[OFS_NEG_RECAL + k] = RST_NEG_RECAL;
      img[OFS_OPTIONS + k]   = RST_OPTIONS;
    end
    img[OFS_GLOBAL]       = RST_GLOBAL;
    img[OFS_SPACING_BAUD] = RST_SPACING_BAUD;
    img[OFS_FLOOR]        = RST_FLOOR_LO;
    img[OFS_FLOOR + 1]    = RST_FLOOR_HI;
    img[OFS_ALERT_CTRL]   = RST_ALERT_CTRL;
    return img;
  endfunction : default_image

  // One byte of CRC-16, most significant bit first.
  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      x = x[15] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    end
    return x;
  endfunction : crc16_step

  localparam image_type DEF_IMAGE = default_image();

  // Reset leaves the alert idle: default polarity is active low, so the pin sits high.
  localparam state_type STATE_RESET = '{
    ld: LD_IDLE, saw_setup: 1'b0, cnt: 8'h00, crc: CRC_INIT, crc_lo: 8'h00,
    shadow: DEF_IMAGE, active: DEF_IMAGE, load_ok: 1'b0, load_bad: 1'b0,
    comms_flag: 1'b0, wd_armed: 1'b0, wd_cnt: 32'h0, wd_pulse: 1'b0,
    pulse_cnt: 32'h0, mains_wait: 1'b0, mains_cnt: 32'h0, mains_err: 1'b0,
    low_sig: 1'b0, sleep_q: 1'b0, alert: 1'b1, key_out: '0, glb_out: '0
  };

  state_type r;
  state_type next_r;

  logic [7:0]  ctrl;
  logic [15:0] floor_val;
  logic        mains_en;
  logic        cond;
  logic [8:0]  ksel;

  // Live settings always come from the committed image, never the staging copy.
  assign ctrl      = r.active[OFS_ALERT_CTRL];
  assign floor_val = {r.active[OFS_FLOOR + 1], r.active[OFS_FLOOR]};
  assign mains_en  = r.active[OFS_GLOBAL][6];
  assign ksel      = {3'b000, key_sel_i};

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    next_r          = r;
    next_r.load_ok  = 1'b0;
    next_r.load_bad = 1'b0;
    next_r.sleep_q  = sleep_i;
    cond            = 1'b0;

    unique case (r.ld)
      LD_IDLE: begin
        if (rx_valid_i) begin
          next_r.saw_setup = (rx_byte_i == SETUP_CMD);
          if (r.saw_setup && rx_byte_i == SETUP_CMD) begin
            next_r.ld        = LD_SETUP;
            next_r.saw_setup = 1'b0;
          end
        end
      end
      LD_SETUP: begin
        // The load command byte itself is kept out of the checksum.
        if (rx_valid_i) begin
          next_r.ld  = LD_LOAD;
          next_r.cnt = 8'h00;
          next_r.crc = CRC_INIT;
        end
      end
      LD_LOAD: begin
        // Checksum over parameter bytes, low byte first.
        if (rx_valid_i) begin
          next_r.cnt = r.cnt + 8'h01;
          if (r.cnt < 8'(OFS_CHECKSUM)) begin
            next_r.shadow[r.cnt] = rx_byte_i;
            next_r.crc           = crc16_step(r.crc, rx_byte_i);
          end else if (r.cnt == 8'(OFS_CHECKSUM)) begin
            next_r.crc_lo = rx_byte_i;
          end else begin
            next_r.ld = LD_IDLE;
            if ({rx_byte_i, r.crc_lo} == r.crc) begin
              next_r.active  = r.shadow;
              next_r.load_ok = 1'b1;
            end else begin
              next_r.load_bad = 1'b1;
            end
          end
        end
      end
    endcase

    next_r.low_sig = ({5'b00000, key_signal_i} < floor_val);

    // Comms error latch; a new error beats a same-cycle clear.
    if (unknown_cmd_i && ctrl[ALB_COMMS_ERR]) begin
      next_r.comms_flag = 1'b1;
    end else if (get_last_cmd_i) begin
      next_r.comms_flag = 1'b0;
    end

    if (valid_cmd_i) begin
      next_r.wd_armed = 1'b1;
    end

    if (r.wd_pulse) begin
      next_r.wd_cnt    = 32'h0;
      next_r.pulse_cnt = r.pulse_cnt + 32'h1;
      if (r.pulse_cnt == WD_PULSE_CYC - 32'h1) begin
        next_r.wd_pulse  = 1'b0;
        next_r.pulse_cnt = 32'h0;
      end
    end else if (rx_valid_i || !r.wd_armed || !ctrl[ALB_WATCHDOG]) begin
      next_r.wd_cnt = 32'h0;
    end else if (r.wd_cnt == WD_TIMEOUT_CYC - 32'h1) begin
      next_r.wd_cnt   = 32'h0;
      next_r.wd_pulse = 1'b1;
    end else begin
      next_r.wd_cnt = r.wd_cnt + 32'h1;
    end

    // Mains sync timeout; an edge clears the error and stops the wait.
    if (!mains_en || mains_edge_i) begin
      next_r.mains_wait = 1'b0;
      next_r.mains_cnt  = 32'h0;
      next_r.mains_err  = 1'b0;
    end else if (scan_done_i && !r.mains_wait) begin
      next_r.mains_wait = 1'b1;
      next_r.mains_cnt  = 32'h0;
    end else if (r.mains_wait) begin
      next_r.mains_cnt = r.mains_cnt + 32'h1;
      if (r.mains_cnt == MAINS_CYC - 32'h1) begin
        next_r.mains_err  = 1'b1;
        next_r.mains_wait = 1'b0;
      end
    end

    cond = (ctrl[ALB_KEY_ERR]   && (key_error_i || r.low_sig))
         | (ctrl[ALB_TOUCH]     && key_touch_i)
         | (ctrl[ALB_SLEEP]     && sleep_i)
         | (ctrl[ALB_NVM_ERR]   && nvm_error_i)
         | (ctrl[ALB_MAINS_ERR] && r.mains_err)
         | (ctrl[ALB_COMMS_ERR] && r.comms_flag)
         | (ctrl[ALB_WATCHDOG]  && r.wd_pulse);

    // Freeze during sleep; the first sleep cycle still updates.
    if (!(sleep_i && r.sleep_q)) begin
      next_r.alert = ctrl[ALB_POLARITY] ? cond : !cond;
    end

    // Thresholds with bias, per selected key.
    if (key_sel_i < 6'(NUM_KEYS)) begin
      next_r.key_out.neg_threshold = {1'b0, r.active[OFS_THRESH + ksel][3:0]} + THRESH_BIAS;
      next_r.key_out.pos_threshold = {1'b0, r.active[OFS_THRESH + ksel][7:4]} + THRESH_BIAS;
      next_r.key_out.neg_drift_rate = r.active[OFS_DRIFT + ksel][3:0];
      next_r.key_out.pos_drift_rate = r.active[OFS_DRIFT + ksel][7:4];
      next_r.key_out.normal_integrator_limit = r.active[OFS_INTEG + ksel][3:0];
      next_r.key_out.fast_integrator_limit   = r.active[OFS_INTEG + ksel][7:4];
      next_r.key_out.neg_recal_delay = r.active[OFS_NEG_RECAL + ksel];
      next_r.key_out.pos_recal_delay      = r.active[OFS_OPTIONS + ksel][3:0];
      next_r.key_out.burst_length         = r.active[OFS_OPTIONS + ksel][5:4];
      next_r.key_out.adjacent_suppress    = r.active[OFS_OPTIONS + ksel][6];
      next_r.key_out.scope_trigger_enable = r.active[OFS_OPTIONS + ksel][7];
    end else begin
      next_r.key_out = '0;
    end

    next_r.glb_out.release_margin    = r.active[OFS_GLOBAL][3:0];
    next_r.glb_out.dwell_code        = r.active[OFS_GLOBAL][5:4];
    next_r.glb_out.mains_lock_enable = mains_en;
    next_r.glb_out.burst_spacing     = r.active[OFS_SPACING_BAUD][3:0];
    next_r.glb_out.baud_select       = r.active[OFS_SPACING_BAUD][7:4];
    next_r.glb_out.signal_floor      = floor_val;
    next_r.glb_out.alert_pin_control = ctrl;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Reset image carries the default alert control byte.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= STATE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Every output except setup_mode_o is a flop of the state struct; setup_mode_o is decoded from r.ld.
  assign alert_pin_o    = r.alert;
  assign setup_mode_o   = (r.ld != LD_IDLE);
  assign load_ok_o      = r.load_ok;
  assign load_bad_o     = r.load_bad;
  assign low_signal_o   = r.low_sig;
  assign mains_error_o  = r.mains_err;
  assign key_setup_o    = r.key_out;
  assign global_setup_o = r.glb_out;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_wd_fire;
    $rose(r.wd_pulse);
  endsequence
  sequence s_wd_hold;
    r.wd_pulse [*8];
  endsequence
  a_alert_touch: assert property (
    !sleep_i && !r.sleep_q && ctrl[ALB_TOUCH] && key_touch_i |=> alert_pin_o == $past(ctrl[7]))
    else $error("touch did not drive alert active");
  a_alert_polar: assert property (
    (!sleep_i && !r.sleep_q && !cond) |=> (alert_pin_o == !$past(ctrl[7])))
    else $error("idle alert level wrong for polarity");
  a_alert_keyerr: assert property (
    !sleep_i && !r.sleep_q && ctrl[ALB_KEY_ERR] && key_error_i |=> alert_pin_o == $past(ctrl[7]))
    else $error("key error did not raise alert");
  a_alert_sleep: assert property (
    (ctrl[ALB_SLEEP] && sleep_i && !r.sleep_q) |=> (alert_pin_o == $past(ctrl[7])))
    else $error("sleep indication missing");
  a_sleep_hold: assert property (
    (sleep_i && r.sleep_q) |=> $stable(alert_pin_o))
    else $error("alert moved during sleep");
  a_comms_latch: assert property (
    (unknown_cmd_i && ctrl[ALB_COMMS_ERR]) |=> r.comms_flag)
    else $error("comms error not latched");
  a_wd_disarmed: assert property (
    !r.wd_armed |-> (r.wd_cnt == 32'h0 && !r.wd_pulse))
    else $error("watchdog ran before first command");
  a_wd_pulse: assert property (
    s_wd_fire |-> s_wd_hold or (r.wd_pulse throughout (##[0:7] $fell(r.wd_pulse))))
    else $error("watchdog pulse too short");
  a_mains_err: assert property (
    (r.mains_wait && mains_en && !mains_edge_i && r.mains_cnt == MAINS_CYC - 32'h1)
      |=> mains_error_o)
    else $error("mains timeout did not flag");
  a_mains_alert: assert property (
    !sleep_i && !r.sleep_q && ctrl[ALB_MAINS_ERR] && r.mains_err |=> alert_pin_o == $past(ctrl[7]))
    else $error("mains error did not raise alert");
  a_load_gate: assert property (
    (r.ld != LD_LOAD) |=> $stable(r.active) || $past(r.ld) == LD_LOAD)
    else $error("image changed outside setup load");
  a_floor_cmp: assert property (
    ({5'b00000, key_signal_i} < floor_val) |=> low_signal_o)
    else $error("low signal not flagged");

endmodule : setup_block_alert_output

`default_nettype wire

// ### dv/host_model.sv
// Purpose: Host model that feeds setup blocks into the byte strobe port.
// Assumes: One byte per clock, changed just after the rising edge.
// Notes:   The bench fills img; the model appends the checksum bytes.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic  clk_i,
  output logic       valid_o,
  output logic [7:0] byte_o
);
  // ---------------------------------------------------------------------------
  // Byte sender
  // ---------------------------------------------------------------------------
  logic [7:0]  img [0:246];
  logic [15:0] crc;

  // Idle data is inverted so a stale byte never looks like a fresh one.
  initial begin
    valid_o = 1'b0;
    byte_o  = 8'h00;
  end

  // A single command byte, strobe dropped afterwards.
  task automatic byte1(input logic [7:0] b);
    @(posedge clk_i);
    valid_o <= 1'b1;
    byte_o  <= b;
    @(posedge clk_i);
    valid_o <= 1'b0;
    byte_o  <= ~b;
  endtask : byte1

  // Strobe stays high across the block so bytes go back to back.
  task automatic send(input bit setup, input bit bad);
    int i;
    crc = 16'h0000;
    for (i = 0; i < 245; i++) begin
      crc = crc ^ {img[i], 8'h00};
      repeat (8) crc = {crc[14:0], 1'b0} ^ (crc[15] ? 16'h1021 : 16'h0000);
    end
    img[245] = bad ? ~crc[7:0] : crc[7:0];
    img[246] = crc[15:8];
    @(posedge clk_i);
    valid_o <= 1'b1;
    for (i = setup ? 0 : 3; i < 250; i++) begin
      byte_o <= (i < 2) ? 8'h01 : (i == 2) ? 8'hA5 : img[i-3];
      @(posedge clk_i);
    end
    valid_o <= 1'b0;
    byte_o  <= ~byte_o;
  endtask : send
endmodule : host_model
`default_nettype wire

// ### dv/setup_block_alert_output_test.sv
// Purpose: Self-checking bench for the setup loader and the alert pin.
// Assumes: Short watchdog and mains counts; the host model sends blocks.
// Notes:   Inputs change by non-blocking assignment on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module setup_block_alert_output_test
  import setup_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------------------
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, rx_valid_i, valid_cmd_i, unknown_cmd_i;
  logic get_last_cmd_i, key_error_i, key_touch_i, sleep_i, nvm_error_i, scan_done_i;
  logic mains_edge_i, alert_pin_o, setup_mode_o, load_ok_o, load_bad_o, low_signal_o;
  logic mains_error_o;
  logic [7:0] rx_byte_i;
  logic [10:0] key_signal_i;
  logic [5:0] key_sel_i;
  key_setup_type key_setup_o;
  global_setup_type global_setup_o, gexp;
  int seed = 32'h57F08695;
  int error_cnt = 0, n_compared = 0, i, n;

  // Counts are shortened so a watchdog period fits in a short run.
  setup_block_alert_output #(.WD_TIMEOUT_CYC(50), .WD_PULSE_CYC(10), .MAINS_CYC(20)) dut_u (
    .clk_sys_i, .arst_n_i, .rx_valid_i, .rx_byte_i, .valid_cmd_i, .unknown_cmd_i,
    .get_last_cmd_i, .key_error_i, .key_touch_i, .sleep_i, .nvm_error_i, .scan_done_i,
    .mains_edge_i, .key_signal_i, .key_sel_i, .alert_pin_o, .setup_mode_o, .load_ok_o,
    .load_bad_o, .low_signal_o, .mains_error_o, .key_setup_o, .global_setup_o);
  host_model host_u (.clk_i(clk_sys_i), .valid_o(rx_valid_i), .byte_o(rx_byte_i));

  // A 5 ns clock.
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string w, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", w, e, g);
    end
  endtask : chk

  task automatic finish_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  function automatic int rnd(input int m);
    return int'($unsigned($random(seed)) % m);
  endfunction : rnd

  function automatic logic alert_exp(input logic [7:0] c, input logic ke, kt, sl, nv);
    logic a;
    a = (c[6] & ke) | (c[5] & kt) | (c[4] & sl) | (c[3] & nv);
    return c[7] ? a : ~a;
  endfunction : alert_exp

  function automatic key_setup_type key_exp(input int k);
    logic [7:0] t, d, g, r, o;
    t = host_u.img[k];
    d = host_u.img[48 + k];
    g = host_u.img[96 + k];
    r = host_u.img[144 + k];
    o = host_u.img[192 + k];
    return {{1'b0, t[3:0]} + 5'd4, {1'b0, t[7:4]} + 5'd4, d[3:0], d[7:4], g[3:0], g[7:4], r,
            o[3:0], o[5:4], o[6], o[7]};
  endfunction : key_exp

  task automatic waitc(input int m);
    repeat (m) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : waitc

  // Counts cycles where the active-low alert is asserted.
  task automatic cnt(input int m);
    n = 0;
    repeat (m) begin
      @(negedge clk_sys_i);
      n += int'(alert_pin_o !== 1'b1);
    end
  endtask : cnt

  task automatic pulse(input int w);
    @(posedge clk_sys_i);
    unknown_cmd_i <= (w == 0);
    get_last_cmd_i <= (w == 1);
    scan_done_i <= (w == 2);
    mains_edge_i <= (w == 3);
    valid_cmd_i <= (w == 4);
    @(posedge clk_sys_i);
    {unknown_cmd_i, get_last_cmd_i, scan_done_i, mains_edge_i, valid_cmd_i} <= 5'h00;
  endtask : pulse

  // Random image; fast limit kept nonzero and 255 delay avoided.
  task automatic load(input logic [7:0] c, input bit s, input bit bad, input bit lk);
    logic ok, ng;
    logic [10:0] fl;
    int j, k;
    fl = 11'(rnd(2048));
    for (j = 0; j < 240; j++) begin
      host_u.img[j] = s ? 8'(rnd(256)) : 8'h55;
    end
    for (j = 0; j < 48; j++) begin
      host_u.img[96 + j][4] = 1'b1;
      if (host_u.img[144 + j] == 8'hFF) host_u.img[144 + j] = 8'h00;
    end
    host_u.img[240] = {1'b0, lk, 2'(rnd(3)), 4'(rnd(16))};
    host_u.img[241] = {4'(rnd(5)), 4'(rnd(12))};
    host_u.img[242] = fl[7:0];
    host_u.img[243] = {5'h00, fl[10:8]};
    host_u.img[244] = c;
    fork
      host_u.send(s, bad);
      begin
        waitc(8);
        chk("setup_mode", s, setup_mode_o);
      end
    join
    ok = 1'b0;
    ng = 1'b0;
    repeat (3) begin
      @(negedge clk_sys_i);
      ok |= load_ok_o;
      ng |= load_bad_o;
    end
    chk("load_ok", s & ~bad, ok);
    chk("load_bad", s & bad, ng);
    if (s & ~bad) begin
      gexp = {host_u.img[240][3:0], host_u.img[240][5:4], host_u.img[240][6],
              host_u.img[241][3:0], host_u.img[241][7:4], host_u.img[243], host_u.img[242], c};
    end
    chk("global", gexp, global_setup_o);
    for (j = 0; j < 2; j++) begin
      k = (j == 0) ? 47 : rnd(48);
      @(posedge clk_sys_i);
      key_sel_i <= 6'(k);
      waitc(1);
      if (s & ~bad) chk("key_setup", key_exp(k), key_setup_o);
    end
  endtask : load

  // Random conditions with the signal at or just under the floor.
  task automatic walk();
    logic ke, kt, nv, lo;
    logic [10:0] sg;
    logic [7:0] c;
    c = gexp.alert_pin_control;
    repeat (30) begin
      ke = 1'(rnd(2));
      kt = 1'(rnd(2));
      nv = 1'(rnd(2));
      sg = gexp.signal_floor[10:0] - 11'(rnd(2));
      lo = sg < gexp.signal_floor[10:0];
      @(posedge clk_sys_i);
      {key_error_i, key_touch_i, nvm_error_i} <= {ke, kt, nv};
      key_signal_i <= sg;
      waitc(3);
      chk("low_signal", lo, low_signal_o);
      chk("alert", alert_exp(c, ke | lo, kt, 1'b0, nv), alert_pin_o);
    end
  endtask : walk

  // Touch drops while asleep; the pin must keep its level until wake.
  task automatic sleep_chk();
    logic [7:0] c;
    c = gexp.alert_pin_control;
    @(posedge clk_sys_i);
    {key_error_i, key_touch_i, nvm_error_i} <= 3'b010;
    key_signal_i <= 11'h7FF;
    waitc(3);
    @(posedge clk_sys_i);
    sleep_i <= 1'b1;
    waitc(3);
    @(posedge clk_sys_i);
    key_touch_i <= 1'b0;
    waitc(3);
    chk("alert_sleep", alert_exp(c, 1'b0, 1'b1, 1'b1, 1'b0), alert_pin_o);
    @(posedge clk_sys_i);
    sleep_i <= 1'b0;
    waitc(3);
    chk("alert_wake", alert_exp(c, 1'b0, 1'b0, 1'b0, 1'b0), alert_pin_o);
  endtask : sleep_chk

  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end

  // Main sequence.
  initial begin
    {valid_cmd_i, unknown_cmd_i, get_last_cmd_i, key_error_i, key_touch_i} = 5'h00;
    {sleep_i, nvm_error_i, scan_done_i, mains_edge_i, key_sel_i} = 10'h000;
    key_signal_i = 11'h7FF;
    gexp = {RST_GLOBAL[3:0], RST_GLOBAL[5:4], RST_GLOBAL[6], 8'h00, 16'h0064, 8'h6C};
    waitc(5);
    chk("alert_reset", 1'b1, alert_pin_o);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    waitc(2);
    chk("global_reset", gexp, global_setup_o);
    walk();
    for (i = 0; i < 4; i++) begin
      load((i == 0) ? 8'hE8 : (i == 1) ? 8'h70 : 8'(rnd(256)) & 8'hFC, 1'b1, 1'b0, 1'b0);
      walk();
      sleep_chk();
    end
    load(8'h11, 1'b1, 1'b1, 1'b0);
    load(8'h22, 1'b0, 1'b0, 1'b0);
    load(8'h07, 1'b1, 1'b0, 1'b1);
    cnt(120);
    chk("wd_disarmed", 0, n);
    pulse(0);
    waitc(20);
    chk("alert_comms", 1'b0, alert_pin_o);
    pulse(1);
    waitc(3);
    chk("alert_cleared", 1'b1, alert_pin_o);
    pulse(2);
    waitc(10);
    chk("mains_early", 1'b0, mains_error_o);
    waitc(15);
    chk("mains_error", 1'b1, mains_error_o);
    chk("alert_mains", 1'b0, alert_pin_o);
    pulse(3);
    waitc(3);
    chk("mains_clear", 1'b0, mains_error_o);
    fork
      host_u.byte1(8'h5A);
      pulse(4);
    join
    cnt(45);
    chk("wd_quiet", 0, n);
    cnt(55);
    chk("wd_pulse", 10, n);
    finish_test();
  end
endmodule : setup_block_alert_output_test
`default_nettype wire
